//--- rtl/dcad_map.vh
// Purpose: Constants for the command/address input decode block
// Assumes: Included by dcad_top.v and by the monitor and bench, by bare name
// Notes:   Offsets are byte addresses on the APB register window
`ifndef DCAD_MAP_VH
`define DCAD_MAP_VH

// Clock period of pclk in ns
`define DCAD_PCLK_PERIOD_NS 8

// APB register offsets
`define DCAD_OFF_CTRL       12'h000
`define DCAD_OFF_STATUS     12'h004
`define DCAD_OFF_OPEN_BANKS 12'h008
`define DCAD_OFF_LAST_CMD   12'h00C
`define DCAD_OFF_CMD_COUNT  12'h010

// Control register fields and reset value
`define DCAD_CTRL_DEC_EN_BIT 0
`define DCAD_CTRL_RESET      1'h1

// Status register field positions
`define DCAD_STAT_PWR_LSB  0
`define DCAD_STAT_TERM_BIT 4
`define DCAD_STAT_RTT_LSB  8

// Last command register field positions
`define DCAD_LAST_CODE_LSB  0
`define DCAD_LAST_BANK_LSB  8
`define DCAD_LAST_GROUP_LSB 12

// Decoded command codes
`define DCAD_CMD_NOP 4'h0
`define DCAD_CMD_ACT 4'h1
`define DCAD_CMD_MRS 4'h2
`define DCAD_CMD_REF 4'h3
`define DCAD_CMD_PRE 4'h4
`define DCAD_CMD_WR  4'h5
`define DCAD_CMD_RD  4'h6
`define DCAD_CMD_ZQ  4'h7
`define DCAD_CMD_RFU 4'h8

// Address bit positions with extra meaning
`define DCAD_AP_BIT   10
`define DCAD_CHOP_BIT 12

// Mode register one select and its termination field
`define DCAD_MR1_SEL     3'h1
`define DCAD_NOMINAL_TERMINATION_LSB 8
`define DCAD_NOMINAL_TERMINATION_OFF 3'h0

`endif

//--- rtl/dcad_sync.v
// Purpose: Two flip-flop synchroniser for a bundle of pin inputs
// Assumes: Each bit is an independent level from outside pclk
// Notes:   Only the second stage is visible to other logic
module dcad_sync #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta; // First stage, read by q only

  // Two stages against metastability
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // dcad_sync

//--- rtl/dcad_top.v
// Purpose: Command/address input stage of a DDR4 SDRAM die
// Assumes: Pins are slow against pclk; ck period well above 4 pclk
// Notes:   Registers on APB: CTRL, STATUS, OPEN_BANKS, LAST_CMD, CMD_COUNT
// What this block does
// - Capture inputs on true rise, complement fall
// - Clock gate high runs clocks, buffers, drivers
// - Gate low with refresh: self refresh; otherwise power-down, active or precharge by open banks
// - Self refresh exit needs no clock edge
// - Power-down disables command buffers; self refresh also disables clock and termination buffers
// - Select high masks commands; select is command bit
// - Termination high applies nominal termination to pins
// - Termination pin ignored when mode one disables it
// - Bank select picks bank or mode register
// - Group select picks group; bit zero picks register
// - Activate low: multi-function pins are row bits
// - Activate high: multi-function pins are command bits
// - Read/write auto-precharge bit closes bank as the command is taken
// - Precharge bit high precharges all banks
// - Chop bit low shortens burst on the fly
// - Row on activate, column on read/write
// - Mode register set takes op-code from address
//
// Local design decisions: the placing of the registers and the APB slave port.
`include "dcad_map.vh"
module dcad_top #(
  parameter BA_W = 2,  // Bank select width
  parameter BG_W = 1,  // Group select width, one on the sixteen-bit part
  parameter A_W  = 14  // Plain address pins A0 upward
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire [11:0]     paddr,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  input  wire            ck_t,
  input  wire            ck_c,
  input  wire            clock_gate_in,
  input  wire            select_n,
  input  wire            activate_n,
  input  wire            row_strobe_or_addr16,
  input  wire            col_strobe_or_addr15,
  input  wire            write_strobe_or_addr14,
  input  wire            term_ctl_in,
  input  wire [BA_W-1:0] bank_sel,
  input  wire [BG_W-1:0] group_sel,
  input  wire [A_W-1:0]  addr_bus,
  output reg             int_clk_en,
  output reg             out_drv_en,
  output reg             ck_buf_en,
  output reg             term_buf_en,
  output reg             cmd_buf_en,
  output reg  [3:0]      pwr_state,
  output reg             cmd_valid,
  output reg  [3:0]      cmd_code,
  output reg  [BA_W-1:0] cmd_bank,
  output reg  [BG_W-1:0] cmd_group,
  output reg  [A_W+2:0]  cmd_row,
  output reg  [9:0]      cmd_col,
  output reg             cmd_auto_pre,
  output reg             cmd_chop,
  output reg             cmd_pre_all,
  output reg  [2:0]      mrs_sel,
  output reg  [A_W-1:0]  mrs_opcode,
  output reg  [2:0]      nominal_termination_code,
  output reg             term_dq,
  output reg             term_upper_strobe,
  output reg             term_lower_strobe,
  output reg             term_upper_mask,
  output reg             term_lower_mask
);

  localparam NB   = 1 << (BA_W + BG_W); // Number of banks
  localparam PW   = 9 + BA_W + BG_W + A_W; // Synchronised pin bundle width
  // Power states, one-hot
  localparam ST_ACT = 4'b0001;
  localparam ST_PPD = 4'b0010;
  localparam ST_APD = 4'b0100;
  localparam ST_SRF = 4'b1000;

  // Standard DDR4 command decode from the four command pins
  function [3:0] dcad_decode;
    input act_n_f;
    input [2:0] rcw;
    begin
      if (!act_n_f) begin
        dcad_decode = `DCAD_CMD_ACT;
      end else begin
        case (rcw)
          3'b000:  dcad_decode = `DCAD_CMD_MRS;
          3'b001:  dcad_decode = `DCAD_CMD_REF;
          3'b010:  dcad_decode = `DCAD_CMD_PRE;
          3'b011:  dcad_decode = `DCAD_CMD_RFU;
          3'b100:  dcad_decode = `DCAD_CMD_WR;
          3'b101:  dcad_decode = `DCAD_CMD_RD;
          3'b110:  dcad_decode = `DCAD_CMD_ZQ;
          default: dcad_decode = `DCAD_CMD_NOP;
        endcase
      end
    end
  endfunction

  wire [PW-1:0]   pins_s;     // All pins after two flops
  wire            ck_t_s;     // Synced true clock
  wire            ck_c_s;     // Synced complement clock
  wire            cke_s;      // Synced clock gate
  wire            cs_n_s;     // Synced select
  wire            act_n_s;    // Synced activate
  wire [2:0]      rcw_s;      // Synced multi-function pins
  wire            odt_s;      // Synced termination control
  wire [BA_W-1:0] ba_s;       // Synced bank select
  wire [BG_W-1:0] bg_s;       // Synced group select
  wire [A_W-1:0]  a_s;        // Synced address bus

  reg             ck_t_d;     // Last synced true clock, for edge find
  reg             cke_q;      // Clock gate as captured at last clock edge
  reg             odt_q;      // Termination pin as captured
  reg  [3:0]      state;      // Power state
  reg  [NB-1:0]   open_banks; // One bit per bank with an open row
  reg             dec_en;     // Software decode enable
  reg  [31:0]     cmd_count;  // Accepted commands
  reg  [15:0]     last_cmd;   // Last accepted command summary

  // Synchronise every pin, clocks included
  dcad_sync #(.W(PW)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({ck_t, ck_c, clock_gate_in, select_n, activate_n,
                row_strobe_or_addr16, col_strobe_or_addr15, write_strobe_or_addr14,
                term_ctl_in, bank_sel, group_sel, addr_bus}),
    .q       (pins_s)
  );

  assign {ck_t_s, ck_c_s, cke_s, cs_n_s, act_n_s, rcw_s, odt_s} = pins_s[PW-1:PW-9];
  assign ba_s = pins_s[BA_W+BG_W+A_W-1:BG_W+A_W];
  assign bg_s = pins_s[BG_W+A_W-1:A_W];
  assign a_s  = pins_s[A_W-1:0];

  // Rise of true clock while complement is low
  wire ck_rise = ck_t_s & ~ck_t_d & ~ck_c_s;
  wire [3:0] code = dcad_decode(act_n_s, rcw_s);
  wire [BA_W+BG_W-1:0] bidx = {bg_s, ba_s};
  // Commands need gate high now and at the prior edge, select low, awake
  wire take = ck_rise & cke_s & cke_q & ~cs_n_s & dec_en & (state == ST_ACT);
  wire any_open = |open_banks;
  wire [2:0] sel3 = {bg_s[0], ba_s[1:0]};

  // Edge finder history and captured gate level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_t_d <= 1'b0;
      cke_q  <= 1'b0;
      odt_q  <= 1'b0;
    end else begin
      ck_t_d <= ck_t_s;
      if (state == ST_SRF) begin
        // Only the gate buffer is alive in self refresh
        odt_q <= 1'b0;
        if (cke_s) begin
          cke_q <= 1'b1;
        end
      end else if (ck_rise) begin
        cke_q <= cke_s;
        odt_q <= odt_s;
      end
    end
  end

  // Power state machine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_ACT;
    end else begin
      case (state)
        ST_ACT: begin
          // Falling gate at a clock edge picks the low-power state
          if (ck_rise && cke_q && !cke_s) begin
            if (!cs_n_s && code == `DCAD_CMD_REF) begin
              state <= ST_SRF;
            end else if (any_open) begin
              state <= ST_APD;
            end else begin
              state <= ST_PPD;
            end
          end
        end
        ST_PPD, ST_APD: begin
          // Exit needs a qualified clock edge
          if (ck_rise && cke_s) begin
            state <= ST_ACT;
          end
        end
        ST_SRF: begin
          // Exit is asynchronous to the link clock
          if (cke_s) begin
            state <= ST_ACT;
          end
        end
        default: state <= ST_ACT;
      endcase
    end
  end

  // Buffer and driver enables follow the power state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_clk_en  <= 1'b1;
      out_drv_en  <= 1'b1;
      ck_buf_en   <= 1'b1;
      term_buf_en <= 1'b1;
      cmd_buf_en  <= 1'b1;
      pwr_state   <= ST_ACT;
    end else begin
      int_clk_en  <= (state == ST_ACT);
      out_drv_en  <= (state == ST_ACT);
      cmd_buf_en  <= (state == ST_ACT);
      ck_buf_en   <= (state != ST_SRF);
      term_buf_en <= (state != ST_SRF);
      pwr_state   <= state;
    end
  end

  // Command decode and field capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid    <= 1'b0;
      cmd_code     <= `DCAD_CMD_NOP;
      cmd_bank     <= {BA_W{1'b0}};
      cmd_group    <= {BG_W{1'b0}};
      cmd_row      <= {(A_W+3){1'b0}};
      cmd_col      <= 10'h000;
      cmd_auto_pre <= 1'b0;
      cmd_chop     <= 1'b0;
      cmd_pre_all  <= 1'b0;
      mrs_sel      <= 3'h0;
      mrs_opcode   <= {A_W{1'b0}};
    end else begin
      cmd_valid <= take;
      if (take) begin
        cmd_code     <= code;
        cmd_bank     <= ba_s;
        cmd_group    <= bg_s;
        cmd_row      <= {A_W+3{1'b0}};
        cmd_col      <= 10'h000;
        cmd_auto_pre <= 1'b0;
        cmd_chop     <= 1'b0;
        cmd_pre_all  <= 1'b0;
        case (code)
          `DCAD_CMD_ACT: cmd_row <= {rcw_s, a_s};
          `DCAD_CMD_RD, `DCAD_CMD_WR: begin
            cmd_col      <= a_s[9:0];
            cmd_auto_pre <= a_s[`DCAD_AP_BIT];
            cmd_chop     <= ~a_s[`DCAD_CHOP_BIT];
          end
          `DCAD_CMD_PRE: cmd_pre_all <= a_s[`DCAD_AP_BIT];
          `DCAD_CMD_MRS: begin
            mrs_sel    <= sel3;
            mrs_opcode <= a_s;
          end
          default: cmd_row <= {A_W+3{1'b0}};
        endcase
      end
    end
  end

  // Open-row bookkeeping per bank
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_banks <= {NB{1'b0}};
    end else if (take) begin
      case (code)
        `DCAD_CMD_ACT: open_banks[bidx] <= 1'b1;
        `DCAD_CMD_PRE: begin
          if (a_s[`DCAD_AP_BIT]) begin
            open_banks <= {NB{1'b0}};
          end else begin
            open_banks[bidx] <= 1'b0;
          end
        end
        `DCAD_CMD_RD, `DCAD_CMD_WR: begin
          // Auto-precharge closes the bank in the same cycle the command is taken
          if (a_s[`DCAD_AP_BIT]) begin
            open_banks[bidx] <= 1'b0;
          end
        end
        default: open_banks <= open_banks;
      endcase
    end
  end

  // Nominal termination field of mode register one, and pin termination
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nominal_termination_code      <= `DCAD_NOMINAL_TERMINATION_OFF;
      term_dq           <= 1'b0;
      term_upper_strobe <= 1'b0;
      term_lower_strobe <= 1'b0;
      term_upper_mask   <= 1'b0;
      term_lower_mask   <= 1'b0;
    end else begin
      if (take && code == `DCAD_CMD_MRS && sel3 == `DCAD_MR1_SEL) begin
        nominal_termination_code <= a_s[`DCAD_NOMINAL_TERMINATION_LSB+2:`DCAD_NOMINAL_TERMINATION_LSB];
      end
      // Disabled field makes the pin a don't-care
      term_dq           <= odt_q & (nominal_termination_code != `DCAD_NOMINAL_TERMINATION_OFF);
      term_upper_strobe <= odt_q & (nominal_termination_code != `DCAD_NOMINAL_TERMINATION_OFF);
      term_lower_strobe <= odt_q & (nominal_termination_code != `DCAD_NOMINAL_TERMINATION_OFF);
      term_upper_mask   <= odt_q & (nominal_termination_code != `DCAD_NOMINAL_TERMINATION_OFF);
      term_lower_mask   <= odt_q & (nominal_termination_code != `DCAD_NOMINAL_TERMINATION_OFF);
    end
  end

  // Command statistics for software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_count <= 32'h0000_0000;
      last_cmd  <= 16'h0000;
    end else if (psel && penable && pready && pwrite && paddr == `DCAD_OFF_CMD_COUNT) begin
      cmd_count <= 32'h0000_0000; // Write clears; a same-cycle command is dropped
    end else if (take) begin
      cmd_count <= cmd_count + 32'h0000_0001;
      last_cmd  <= {{(4-BG_W){1'b0}}, bg_s, {(4-BA_W){1'b0}}, ba_s, 4'h0, code};
    end
  end

  // APB slave: one wait-free access phase, ready from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      dec_en  <= `DCAD_CTRL_RESET;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
        case (paddr)
          `DCAD_OFF_CTRL:       prdata[`DCAD_CTRL_DEC_EN_BIT] <= dec_en;
          `DCAD_OFF_STATUS:     prdata <= {20'h00000, 1'b0, nominal_termination_code, 3'h0, term_dq, state};
          `DCAD_OFF_OPEN_BANKS: prdata[NB-1:0] <= open_banks;
          `DCAD_OFF_LAST_CMD:   prdata[15:0] <= last_cmd;
          `DCAD_OFF_CMD_COUNT:  prdata <= cmd_count;
          default:              pslverr <= 1'b1;
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == `DCAD_OFF_CTRL) begin
        dec_en <= pwdata[`DCAD_CTRL_DEC_EN_BIT];
      end
    end
  end

endmodule // dcad_top

//--- tb/dcad_host.sv
// Purpose: Controller model driving the command and address pins
// Assumes: Link clock of 125 ns, stoppable for the self refresh exit
// Notes:   Pins move just after a link fall so they straddle each rise
module dcad_host (
  input  wire logic   pclk,
  output logic        ck_t,
  output logic        ck_c,
  output logic        clock_gate_in,
  output logic        select_n,
  output logic        activate_n,
  output logic        row_strobe_or_addr16,
  output logic        col_strobe_or_addr15,
  output logic        write_strobe_or_addr14,
  output logic [1:0]  bank_sel,
  output logic [0:0]  group_sel,
  output logic [13:0] addr_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ck_run = 1'b1;  // Link clock toggles only while set
  assign ck_c = ~ck_t;  // Complement pin

  // Idle pins: gate high, deselected
  initial begin
    {ck_t, clock_gate_in, select_n, activate_n} = 4'h7;
    {row_strobe_or_addr16, col_strobe_or_addr15, write_strobe_or_addr14, group_sel, bank_sel, addr_bus} = 20'h0;
  end

  // Free phase against pclk on purpose
  always begin
    #62.5;
    if (ck_run) ck_t = ~ck_t;
  end

  // One command, then deselect with inverted pins so stale values never look valid
  task automatic send(input logic cs, act, input logic [2:0] rcw, bb, input logic [13:0] a, input logic g);
    @(negedge ck_t);
    @(posedge pclk);
    clock_gate_in <= g;
    {select_n, activate_n, row_strobe_or_addr16, col_strobe_or_addr15, write_strobe_or_addr14,
      group_sel, bank_sel, addr_bus} <= {cs, act, rcw, bb, a};
    @(negedge ck_t);
    @(posedge pclk);
    {select_n, activate_n, row_strobe_or_addr16, col_strobe_or_addr15, write_strobe_or_addr14,
      group_sel, bank_sel, addr_bus} <= {1'b1, ~{act, rcw, bb, a}};
  endtask

  // Gate change with no link edge needed
  task automatic set_gate(input logic g);
    @(posedge pclk);
    clock_gate_in <= g;
  endtask
endmodule // dcad_host

//--- tb/dcad_top_monitor.sv
// Purpose: Port-level checks for the command/address decode block
// Assumes: Pins steady 4 pclk either side of each link rise
// Notes:   Fields are compared with the pins seen 4 pclk before cmd_valid
`include "dcad_map.vh"
module dcad_top_monitor #(
  parameter BA_W = 2,
  parameter BG_W = 1,
  parameter A_W  = 14
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            select_n,
  input wire logic            activate_n,
  input wire logic            row_strobe_or_addr16,
  input wire logic            col_strobe_or_addr15,
  input wire logic            write_strobe_or_addr14,
  input wire logic [BA_W-1:0] bank_sel,
  input wire logic [BA_W-1:0] cmd_bank,
  input wire logic [BG_W-1:0] group_sel,
  input wire logic [BG_W-1:0] cmd_group,
  input wire logic [A_W-1:0]  addr_bus,
  input wire logic [A_W-1:0]  mrs_opcode,
  input wire logic [A_W+2:0]  cmd_row,
  input wire logic [9:0]      cmd_col,
  input wire logic [3:0]      cmd_code,
  input wire logic [3:0]      pwr_state,
  input wire logic [2:0]      mrs_sel,
  input wire logic [2:0]      nominal_termination_code,
  input wire logic            cmd_valid,
  input wire logic            cmd_auto_pre,
  input wire logic            cmd_chop,
  input wire logic            cmd_pre_all,
  input wire logic            term_dq,
  input wire logic            term_upper_strobe,
  input wire logic            int_clk_en,
  input wire logic            out_drv_en,
  input wire logic            cmd_buf_en,
  input wire logic            ck_buf_en,
  input wire logic            term_buf_en
);
  timeunit 1ns;
  timeprecision 100ps;
  // One domain, so one clock and one reset for every check
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read and write share the column path
  wire is_rw = cmd_code == `DCAD_CMD_RD || cmd_code == `DCAD_CMD_WR;

  valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("cmd_valid lasted over one cycle");
  cs_mask_a: assert property (select_n [*6] |-> !cmd_valid)
    else $error("command reported while deselected");
  act_kind_a: assert property (cmd_valid |-> (cmd_code == `DCAD_CMD_ACT) == !$past(activate_n, 4))
    else $error("activate decode wrong");
  act_row_a: assert property (cmd_valid && cmd_code == `DCAD_CMD_ACT |->
    cmd_row == {$past(row_strobe_or_addr16, 4), $past(col_strobe_or_addr15, 4), $past(write_strobe_or_addr14, 4),
    $past(addr_bus, 4)}) else $error("row address wrong");
  rw_col_a: assert property (cmd_valid && is_rw |->
    {cmd_col, cmd_auto_pre, cmd_chop} == {$past(addr_bus[9:0], 4), $past(addr_bus[`DCAD_AP_BIT], 4),
    ~$past(addr_bus[`DCAD_CHOP_BIT], 4)}) else $error("column fields wrong");
  pre_all_a: assert property (cmd_valid && cmd_code == `DCAD_CMD_PRE |->
    cmd_pre_all == $past(addr_bus[`DCAD_AP_BIT], 4)) else $error("precharge-all wrong");
  bank_grp_a: assert property (cmd_valid |-> {cmd_group, cmd_bank} == {$past(group_sel, 4), $past(bank_sel, 4)})
    else $error("bank or group wrong");
  mrs_op_a: assert property (cmd_valid && cmd_code == `DCAD_CMD_MRS |->
    mrs_opcode == $past(addr_bus, 4) && mrs_sel == {$past(group_sel[0], 4), $past(bank_sel, 4)})
    else $error("mode register write wrong");
  term_off_a: assert property (nominal_termination_code == 3'h0 [*2] |-> !term_dq && !term_upper_strobe)
    else $error("termination on while disabled");
  clk_run_a: assert property (int_clk_en == (pwr_state == 4'h1) && out_drv_en == int_clk_en && cmd_buf_en == int_clk_en)
    else $error("clock or driver enable wrong");
  sr_buf_a: assert property (ck_buf_en == (pwr_state != 4'h8) && term_buf_en == ck_buf_en)
    else $error("buffer enable wrong");
  pd_block_a: assert property ((pwr_state != 4'h1) [*6] |-> !cmd_valid)
    else $error("command taken in low power");

  // Main scenarios reached
  cover property (cmd_valid && cmd_code == `DCAD_CMD_ACT);
  cover property (cmd_valid && cmd_code == `DCAD_CMD_MRS);
  cover property (pwr_state == 4'h8);
  cover property (term_dq);
endmodule // dcad_top_monitor

bind dcad_top dcad_top_monitor #(.BA_W(BA_W), .BG_W(BG_W), .A_W(A_W)) u_mon (.*);

//--- tb/tb.sv
// Purpose: Self-checking bench for the command/address decode block
// Assumes: Default widths; the host model drives command pins
// Notes:   Seeded random commands plus register, termination and power cases
`include "dcad_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, term_ctl_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, ck_t, ck_c, clock_gate_in, select_n, activate_n;
  logic        row_strobe_or_addr16, col_strobe_or_addr15, write_strobe_or_addr14;
  logic [1:0]  bank_sel, cmd_bank;
  logic [0:0]  group_sel, cmd_group;
  logic [13:0] addr_bus, mrs_opcode;
  logic [16:0] cmd_row;
  logic [9:0]  cmd_col;
  logic [3:0]  pwr_state, cmd_code;
  logic [2:0]  mrs_sel, nominal_termination_code;
  logic        int_clk_en, out_drv_en, ck_buf_en, term_buf_en, cmd_buf_en, cmd_valid, cmd_auto_pre, cmd_chop;
  logic        cmd_pre_all, term_dq, term_upper_strobe, term_lower_strobe, term_upper_mask, term_lower_mask;
  logic [36:0] cap;  // Fields of the last reported command
  int          err_total = 0, cmp_count = 0, n_cmd = 0;
  // Expected code per strobe pattern with activate high
  localparam logic [3:0] TBL [8] = '{`DCAD_CMD_MRS, `DCAD_CMD_REF, `DCAD_CMD_PRE, `DCAD_CMD_RFU,
    `DCAD_CMD_WR, `DCAD_CMD_RD, `DCAD_CMD_ZQ, `DCAD_CMD_NOP};

  dcad_top uut (.*);
  dcad_host host (.*);

  always #4 pclk = ~pclk;

  // Latch every reported command
  always @(posedge pclk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd <= n_cmd + 1;
      cap <= {cmd_code, cmd_group, cmd_bank, cmd_row, cmd_col, cmd_auto_pre, cmd_chop, cmd_pre_all};
    end
  end

  task automatic check(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; answer lands in rd and er
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int k;
    k = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask

  // Send one command, then compare what the block reported
  task automatic issue(input logic cs, act, input logic [2:0] rcw, bb, input logic [13:0] a, input logic g, ev);
    int n0;
    logic [3:0] c;
    n0 = n_cmd;
    c = act ? TBL[rcw] : `DCAD_CMD_ACT;
    host.send(cs, act, rcw, bb, a, g);
    check(n_cmd - n0, ev);
    if (ev) begin
      check(cap[36:30], {c, bb});
      if (!act) check(cap[29:13], {rcw, a});
      if (c == `DCAD_CMD_RD || c == `DCAD_CMD_WR) check(cap[12:1], {a[9:0], a[10], ~a[12]});
      if (c == `DCAD_CMD_PRE) check(cap[0], a[10]);
      if (c == `DCAD_CMD_MRS) check({mrs_sel, mrs_opcode}, {bb, a});
    end
  endtask

  // Let link edges pass so state and enables settle
  task automatic settle();
    repeat (40) @(posedge pclk);
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h860BEBDE));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Registers, unmapped place, decode enable, deselect
    apb(1'b0, `DCAD_OFF_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, `DCAD_OFF_STATUS, 32'hFFFFFFFF);
    apb(1'b0, `DCAD_OFF_STATUS, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 12'h040, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, `DCAD_OFF_CTRL, 32'h0);
    issue(1'b0, 1'b0, 3'h5, 3'h6, 14'h1111, 1'b1, 1'b0);
    apb(1'b1, `DCAD_OFF_CTRL, 32'h1);
    apb(1'b1, `DCAD_OFF_CMD_COUNT, 32'h0);
    issue(1'b0, 1'b0, 3'h5, 3'h6, 14'h1111, 1'b1, 1'b1);
    issue(1'b1, 1'b0, 3'h2, 3'h1, 14'h2222, 1'b1, 1'b0);
    apb(1'b0, `DCAD_OFF_LAST_CMD, 32'h0);
    check(rd, 32'h1201);
    apb(1'b0, `DCAD_OFF_CMD_COUNT, 32'h0);
    check(rd, 32'h1);
    $display("test registers done");
    // Strobe patterns 0 to 6, then random commands
    for (int i = 0; i < 20; i++) begin
      logic act;
      act = (i < 7) ? 1'b1 : 1'($urandom_range(0, 1));
      issue(1'b0, act, (i < 7) ? 3'(i) : 3'($urandom_range(0, 7)), 3'($urandom), 14'($urandom), 1'b1, 1'b1);
    end
    $display("test decode done");
    // Termination off, on, then pin low
    issue(1'b0, 1'b1, 3'h0, 3'h1, 14'h0000, 1'b1, 1'b1);
    term_ctl_in <= 1'b1;
    settle();
    check({term_dq, term_upper_strobe, term_lower_strobe, term_upper_mask, term_lower_mask}, 5'h00);
    issue(1'b0, 1'b1, 3'h0, 3'h1, 14'h0300, 1'b1, 1'b1);
    settle();
    check({term_dq, term_upper_strobe, term_lower_strobe, term_upper_mask, term_lower_mask}, 5'h1F);
    apb(1'b0, `DCAD_OFF_STATUS, 32'h0);
    check(rd, 32'h311);
    check(nominal_termination_code, 3'h3);
    term_ctl_in <= 1'b0;
    settle();
    check({term_dq, term_upper_strobe, term_lower_strobe, term_upper_mask, term_lower_mask}, 5'h00);
    $display("test termination done");
    // Precharge power-down, blocked command, exit, active power-down
    issue(1'b0, 1'b1, 3'h2, 3'h0, 14'h0400, 1'b1, 1'b1);
    issue(1'b1, 1'b1, 3'h7, 3'h0, 14'h0000, 1'b0, 1'b0);
    settle();
    check({pwr_state, int_clk_en, out_drv_en, cmd_buf_en, ck_buf_en, term_buf_en}, 9'h043);
    issue(1'b0, 1'b0, 3'h0, 3'h0, 14'h0005, 1'b0, 1'b0);
    issue(1'b1, 1'b1, 3'h7, 3'h0, 14'h0000, 1'b1, 1'b0);
    settle();
    check(pwr_state, 4'h1);
    issue(1'b0, 1'b0, 3'h1, 3'h2, 14'h0123, 1'b1, 1'b1);
    apb(1'b0, `DCAD_OFF_OPEN_BANKS, 32'h0);
    check(rd, 32'h4);
    issue(1'b1, 1'b1, 3'h7, 3'h0, 14'h0000, 1'b0, 1'b0);
    settle();
    check(pwr_state, 4'h4);
    issue(1'b1, 1'b1, 3'h7, 3'h0, 14'h0000, 1'b1, 1'b0);
    settle();
    // Self refresh, exit with the link clock stopped
    issue(1'b0, 1'b1, 3'h2, 3'h0, 14'h0400, 1'b1, 1'b1);
    issue(1'b0, 1'b1, 3'h1, 3'h0, 14'h0000, 1'b0, 1'b0);
    settle();
    check({pwr_state, int_clk_en, out_drv_en, cmd_buf_en, ck_buf_en, term_buf_en}, 9'h100);
    host.ck_run <= 1'b0;
    settle();
    host.set_gate(1'b1);
    for (int k = 0; k < 20 && pwr_state !== 4'h1; k++) @(posedge pclk);
    check(pwr_state, 4'h1);
    host.ck_run <= 1'b1;
    settle();
    issue(1'b0, 1'b0, 3'h3, 3'h5, 14'h0ABC, 1'b1, 1'b1);
    $display("test power done");
    wrap_up();
  end
endmodule // tb
